//--- hdl/edm_pkg.sv
// constants shared by the external device monitor block
package device_monitor_pkg;
	localparam int unsigned CLK_KHZ = 10000;
	localparam int unsigned LIMIT_MS = 250;
	localparam int unsigned LIMIT_CYCLES = LIMIT_MS * CLK_KHZ;
	localparam int unsigned TIMER_W = 22;
	localparam int unsigned NUM_OUT = 4;
	localparam int unsigned NUM_MON = 4;
	localparam int unsigned RELAY_CONTACTS = 2;
	localparam int unsigned ADDR_W = 5;
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_MON_ENABLE = 3'h1;
	localparam logic [2:0] IDX_MON_MAP = 3'h2;
	localparam logic [2:0] IDX_MON_MODE = 3'h3;
	localparam logic [2:0] IDX_STATUS = 3'h4;
	localparam int unsigned CTRL_RESET_BIT = 0;
	localparam int unsigned CTRL_AUTO_POS = 8;
	localparam int unsigned MAP_FIELD_W = 2;
	localparam int unsigned STAT_OUT_POS = 0;
	localparam int unsigned STAT_LOCK_POS = 8;
	localparam int unsigned STAT_READY_POS = 16;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_MON_ENABLE = 32'h0000_0000;
	localparam logic [31:0] RST_MON_MAP = 32'h0000_0000;
	localparam logic [31:0] RST_MON_MODE = 32'h0000_0000;
	typedef enum logic [3:0] {
		MON_OFF = 4'b0001,
		MON_ON = 4'b0010,
		MON_WAIT = 4'b0100,
		MON_LOCK = 4'b1000
	} mon_state_t;
endpackage : device_monitor_pkg

//--- hdl/external_device_monitor.sv
// external device monitor with safety output gating and avalon registers
`timescale 1ns/1ns
module external_device_monitor import device_monitor_pkg::*; #(
	parameter int unsigned N_OUT = NUM_OUT,
	parameter int unsigned N_MON = NUM_MON,
	parameter int unsigned CONTACTS = RELAY_CONTACTS,
	parameter int unsigned LIMIT = LIMIT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [N_OUT-1:0] i_run_request,
	input wire logic [N_MON-1:0] i_monitor_a,
	input wire logic [N_MON-1:0] i_monitor_b,
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [N_OUT-1:0] o_safety_switching_output,
	output logic [N_OUT*CONTACTS-1:0] o_relay_output_group,
	output logic [N_MON-1:0] o_lockout
);
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [31:0] mon_enable;
	logic [31:0] next_mon_enable;
	logic [31:0] mon_map;
	logic [31:0] next_mon_map;
	logic [31:0] mon_mode;
	logic [31:0] next_mon_mode;
	logic reset_pulse;
	logic next_reset_pulse;
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic [N_OUT-1:0] out_on;
	logic [N_OUT-1:0] next_out_on;
	logic [N_MON-1:0] mon_used;
	logic [N_MON-1:0] mon_any_on;
	logic [N_MON-1:0] mon_ready;
	logic [N_MON-1:0] mon_lock;
	logic [31:0] status;
	logic accept_write;
	logic [31:0] wmask;

	////////////////////////////////////////////////////////////////////////////
	// output k supervised by monitor m
	function automatic logic maps_to(input logic [31:0] en, input logic [31:0] map,
			input int unsigned k, input int unsigned m);
		logic [MAP_FIELD_W-1:0] idx;
		idx = map[k*MAP_FIELD_W +: MAP_FIELD_W];
		maps_to = en[k] && (32'(idx) == 32'(m));
	endfunction : maps_to

	function automatic logic [MAP_FIELD_W-1:0] map_of(input logic [31:0] map,
			input int unsigned k);
		map_of = map[k*MAP_FIELD_W +: MAP_FIELD_W];
	endfunction : map_of

	////////////////////////////////////////////////////////////////////////////
	// fan outputs into monitors
	always_comb begin
		mon_used = '0;
		mon_any_on = '0;
		for (int unsigned m = 0; m < N_MON; m++) begin
			for (int unsigned k = 0; k < N_OUT; k++) begin
				if (maps_to(mon_enable, mon_map, k, m)) begin
					mon_used[m] = 1'b1;
					mon_any_on[m] = mon_any_on[m] | out_on[k];
				end
			end
		end
	end

	generate
		for (genvar g = 0; g < N_MON; g++) begin : g_mon
			monitor_unit #(
				.LIMIT(LIMIT),
				.TW(TIMER_W)
			) u_mon (
				.i_sys_clk(i_sys_clk),
				.i_sys_rst(i_sys_rst),
				.i_used(mon_used[g]),
				.i_two_channel(mon_mode[g]),
				.i_outputs_on(mon_any_on[g]),
				.i_contact_a(i_monitor_a[g]),
				.i_contact_b(i_monitor_b[g]),
				.i_fault_reset(reset_pulse),
				.o_ready(mon_ready[g]),
				.o_lockout(mon_lock[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// safety output switching
	always_comb begin
		logic gate;
		logic locked;
		logic [MAP_FIELD_W-1:0] idx;
		gate = 1'b0;
		locked = 1'b0;
		idx = '0;
		next_out_on = out_on;
		for (int unsigned k = 0; k < N_OUT; k++) begin
			idx = map_of(mon_map, k);
			locked = mon_enable[k] && mon_lock[idx];
			gate = !mon_enable[k] || (mon_ready[idx] && !mon_lock[idx]);
			if (!i_run_request[k] || locked) begin
				next_out_on[k] = 1'b0;
			end else if (!out_on[k] && gate &&
					(reset_pulse || ctrl[CTRL_AUTO_POS + k])) begin
				next_out_on[k] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			out_on <= '0;
			o_safety_switching_output <= '0;
			o_relay_output_group <= '0;
			o_lockout <= '0;
		end else begin
			out_on <= next_out_on;
			o_safety_switching_output <= next_out_on;
			for (int unsigned k = 0; k < N_OUT; k++) begin
				o_relay_output_group[k*CONTACTS +: CONTACTS] <= {CONTACTS{next_out_on[k]}};
			end
			o_lockout <= mon_lock;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// avalon slave, one wait cycle
	assign accept_write = i_avs_write && !o_avs_waitrequest;
	assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
		{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

	always_comb begin
		status = '0;
		status[STAT_OUT_POS +: N_OUT] = out_on;
		status[STAT_LOCK_POS +: N_MON] = mon_lock;
		status[STAT_READY_POS +: N_MON] = mon_ready;
	end

	always_comb begin
		next_ctrl = ctrl;
		next_mon_enable = mon_enable;
		next_mon_map = mon_map;
		next_mon_mode = mon_mode;
		next_reset_pulse = 1'b0;
		next_waitrequest = 1'b1;
		next_readdata = o_avs_readdata;
		if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
			next_waitrequest = 1'b0;
			unique case (i_avs_address[ADDR_W-1:2])
				IDX_CTRL: next_readdata = ctrl;
				IDX_MON_ENABLE: next_readdata = mon_enable;
				IDX_MON_MAP: next_readdata = mon_map;
				IDX_MON_MODE: next_readdata = mon_mode;
				IDX_STATUS: next_readdata = status;
				default: next_readdata = 32'h0000_0000;
			endcase
		end
		if (accept_write) begin
			unique case (i_avs_address[ADDR_W-1:2])
				IDX_CTRL: begin
					next_ctrl = (ctrl & ~wmask) | (i_avs_writedata & wmask);
					next_ctrl[CTRL_RESET_BIT] = 1'b0;
					next_reset_pulse = i_avs_writedata[CTRL_RESET_BIT] && i_avs_byteenable[0];
				end
				IDX_MON_ENABLE: next_mon_enable = (mon_enable & ~wmask) | (i_avs_writedata & wmask);
				IDX_MON_MAP: next_mon_map = (mon_map & ~wmask) | (i_avs_writedata & wmask);
				IDX_MON_MODE: next_mon_mode = (mon_mode & ~wmask) | (i_avs_writedata & wmask);
				default: next_ctrl = ctrl;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl <= RST_CTRL;
			mon_enable <= RST_MON_ENABLE;
			mon_map <= RST_MON_MAP;
			mon_mode <= RST_MON_MODE;
			reset_pulse <= 1'b0;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			mon_enable <= next_mon_enable;
			mon_map <= next_mon_map;
			mon_mode <= next_mon_mode;
			reset_pulse <= next_reset_pulse;
			o_avs_waitrequest <= next_waitrequest;
			o_avs_readdata <= next_readdata;
		end
	end
endmodule : external_device_monitor

//--- hdl/monitor_unit.sv
// one monitor input pair with its response and disagreement timers
`timescale 1ns/1ns
module monitor_unit import device_monitor_pkg::*; #(
	parameter int unsigned LIMIT = LIMIT_CYCLES,
	parameter int unsigned TW = TIMER_W
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_used,
	input wire logic i_two_channel,
	input wire logic i_outputs_on,
	input wire logic i_contact_a,
	input wire logic i_contact_b,
	input wire logic i_fault_reset,
	output logic o_ready,
	output logic o_lockout
);
	localparam logic [TW-1:0] LAST = TW'(LIMIT - 1);
	localparam logic [TW-1:0] FULL = TW'(LIMIT);
	mon_state_t state;
	mon_state_t next_state;
	logic [TW-1:0] off_count;
	logic [TW-1:0] next_off_count;
	logic [TW-1:0] dis_count;
	logic [TW-1:0] next_dis_count;
	logic closed;
	logic disagree;

	assign closed = i_contact_a && (!i_two_channel || i_contact_b);
	assign disagree = i_two_channel && (i_contact_a != i_contact_b);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_off_count = off_count;
		next_dis_count = '0;
		if (!i_used) begin
			next_state = MON_OFF;
			next_off_count = '0;
		end else begin
			unique case (state)
				MON_OFF: begin
					if (i_outputs_on) begin
						next_state = MON_ON;
					end
				end
				MON_ON: begin
					if (!i_outputs_on) begin
						next_off_count = '0;
						next_state = i_two_channel ? MON_OFF : MON_WAIT;
					end
				end
				MON_WAIT: begin
					if (closed) begin
						next_state = MON_OFF;
					end else if (off_count == LAST) begin
						next_state = MON_LOCK;
					end else begin
						next_off_count = off_count + TW'(1);
					end
				end
				MON_LOCK: begin
					if (i_fault_reset && closed && !disagree) begin
						next_state = MON_OFF;
					end
				end
			endcase
			if (disagree && state != MON_LOCK) begin
				if (dis_count == FULL) begin
					next_state = MON_LOCK;
				end else begin
					next_dis_count = dis_count + TW'(1);
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= MON_OFF;
			off_count <= '0;
			dis_count <= '0;
		end else begin
			state <= next_state;
			off_count <= next_off_count;
			dis_count <= next_dis_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// ready when unused, or when closed in MON_OFF
	assign o_ready = !i_used || (closed && state == MON_OFF);
	assign o_lockout = i_used && state == MON_LOCK;
endmodule : monitor_unit

//--- tb/edm_checker_asserts.sv
// port checker for the external device monitor
`timescale 1ns/1ns
module device_monitor_checker import device_monitor_pkg::*; #(
	parameter int unsigned N_OUT = NUM_OUT,
	parameter int unsigned N_MON = NUM_MON,
	parameter int unsigned CONTACTS = RELAY_CONTACTS,
	parameter int unsigned LIMIT = LIMIT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [N_OUT-1:0] i_run_request,
	input wire logic [N_MON-1:0] i_monitor_a,
	input wire logic [N_MON-1:0] i_monitor_b,
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [N_OUT-1:0] o_safety_switching_output,
	input wire logic [N_OUT*CONTACTS-1:0] o_relay_output_group,
	input wire logic [N_MON-1:0] o_lockout
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////////////////////////////////////
	bus_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	bus_idle_a: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
		else $error("answer without request");
	bus_unmapped_a: assert property (!o_avs_waitrequest && i_avs_read
		&& i_avs_address[4:2] > 3'h4 |-> o_avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	for (genvar k = 0; k < N_OUT; k++) begin : g_out
		relay_group_a: assert property (
			o_relay_output_group[k*CONTACTS +: CONTACTS]
			== {CONTACTS{o_safety_switching_output[k]}}) else $error("relay group split");
		output_drop_a: assert property (!i_run_request[k] |=> !o_safety_switching_output[k])
			else $error("output stayed on");
	end
	////////////////////////////////////////////////////////////////////////
	for (genvar m = 0; m < N_MON; m++) begin : g_mon
		logic [31:0] bad;
		logic [31:0] next_bad;
		// cycles the contacts have been open or disagreeing
		always_comb next_bad = (!i_monitor_a[m] || i_monitor_a[m] != i_monitor_b[m]) ? bad + 1 : '0;
		always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
			if (i_sys_rst) bad <= '0;
			else bad <= next_bad;
		end
		lock_time_a: assert property ($rose(o_lockout[m]) |-> $past(bad, 2) >= LIMIT - 2)
			else $error("lockout too early");
		lock_hold_a: assert property ($fell(o_lockout[m])
			|-> $past(i_avs_write, 2) || $past(i_avs_write, 3)) else $error("lockout left alone");
		lock_release_a: assert property ($fell(o_lockout[m]) |-> $past(i_monitor_a[m], 2))
			else $error("lockout left with open contact");
	end
endmodule : device_monitor_checker

bind external_device_monitor device_monitor_checker #(.N_OUT(N_OUT), .N_MON(N_MON),
	.CONTACTS(CONTACTS), .LIMIT(LIMIT)) checker_i (.i_sys_clk, .i_sys_rst, .i_run_request,
	.i_monitor_a, .i_monitor_b, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
	.o_avs_waitrequest, .o_safety_switching_output, .o_relay_output_group, .o_lockout);

//--- tb/relay_model.sv
// contactors with force-guided monitoring contacts
`timescale 1ns/1ns
module relay_model (
	input wire logic i_sys_clk,
	input wire logic [3:0] i_drive,
	input wire logic [3:0] i_stuck_a,
	input wire logic [3:0] i_stuck_b,
	input wire logic [7:0] i_delay,
	output logic [3:0] o_closed_a,
	output logic [3:0] o_closed_b
);
	logic [3:0] nc = 4'hF;
	int cnt [4] = '{default: 0};
	always @(posedge i_sys_clk) begin
		for (int m = 0; m < 4; m++) begin
			cnt[m] <= (nc[m] == i_drive[m]) ? cnt[m] + 1 : 0;
			if (nc[m] == i_drive[m] && cnt[m] >= i_delay) nc[m] <= !i_drive[m];
		end
	end
	assign o_closed_a = nc & ~i_stuck_a;
	assign o_closed_b = nc & ~i_stuck_b;
endmodule : relay_model

//--- tb/testbench.sv
// self-checking bench for the external device monitor
`timescale 1ns/1ns
module testbench;
	import device_monitor_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] run = 4'h0;
	logic [3:0] mon_a;
	logic [3:0] mon_b;
	logic [3:0] out;
	logic [3:0] lock;
	logic [7:0] relay;
	logic [4:0] addr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic waitreq;
	logic [3:0] stuck_a = 4'h0;
	logic [3:0] stuck_b = 4'h0;
	logic [7:0] dly = 8'h03;
	logic [31:0] q;
	logic [31:0] rst_val [4];
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	initial forever #50 clk = ~clk;
	external_device_monitor #(.LIMIT(20)) DUT (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_run_request(run), .i_monitor_a(mon_a), .i_monitor_b(mon_b), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_safety_switching_output(out),
		.o_relay_output_group(relay), .o_lockout(lock));
	relay_model partner (.i_sys_clk(clk), .i_drive(out), .i_stuck_a(stuck_a),
		.i_stuck_b(stuck_b), .i_delay(dly), .o_closed_a(mon_a), .o_closed_b(mon_b));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task bus(input logic write, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wr <= write;
		rd <= !write;
		addr <= a;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) n_fail++;
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task pulse;
		bus(1'b1, 5'h00, 32'h0000_0001);
		repeat (3) @(posedge clk);
	endtask : pulse
	task close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			close_out;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_val = '{RST_CTRL, RST_MON_ENABLE, RST_MON_MAP, RST_MON_MODE};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 5'(i * 4), 32'h0000_0000);
			chk(q, rst_val[i]);
		end
		bus(1'b1, 5'h14, 32'hFFFF_FFFF);
		bus(1'b0, 5'h14, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		stuck_a <= 4'h1;
		run <= 4'h1;
		pulse;
		chk(out, 4'h1);
		stuck_a <= 4'h0;
		run <= 4'h0;
		repeat (10) @(posedge clk);
		bus(1'b1, 5'h08, 32'h0000_00E4);
		bus(1'b1, 5'h04, 32'h0000_000F);
		bus(1'b1, 5'h0C, 32'h0000_000C);
		stuck_a <= 4'h1;
		stuck_b <= 4'h4;
		run <= 4'hF;
		pulse;
		chk(out, 4'hA);
		chk(relay, 8'hCC);
		stuck_a <= 4'h0;
		stuck_b <= 4'h0;
		repeat (2) @(posedge clk);
		pulse;
		chk(out, 4'hF);
		repeat (30) @(posedge clk);
		chk(out, 4'hF);
		chk(lock, 4'h0);
		run <= 4'hD;
		repeat (30) @(posedge clk);
		chk(lock, 4'h0);
		dly <= 8'h28;
		run <= 4'hC;
		repeat (30) @(posedge clk);
		chk(lock, 4'h1);
		repeat (20) @(posedge clk);
		stuck_a <= 4'h1;
		run <= 4'hD;
		pulse;
		chk(lock, 4'h1);
		chk(out, 4'hC);
		stuck_a <= 4'h0;
		repeat (3) @(posedge clk);
		pulse;
		chk(lock, 4'h0);
		pulse;
		chk(out, 4'hD);
		dly <= 8'h03;
		stuck_b <= 4'h8;
		run <= 4'h5;
		repeat (10) @(posedge clk);
		chk(lock, 4'h0);
		repeat (25) @(posedge clk);
		chk(lock, 4'h8);
		bus(1'b0, 5'h10, 32'h0000_0000);
		chk(q, 32'h0002_0805);
		stuck_a <= 4'h2;
		run <= 4'h7;
		be <= 4'h2;
		bus(1'b1, 5'h00, 32'hFFFF_0201);
		be <= 4'hF;
		bus(1'b0, 5'h00, 32'h0000_0000);
		chk(q, 32'h0000_0200);
		chk(out, 4'h5);
		stuck_a <= 4'h0;
		repeat (3) @(posedge clk);
		chk(out, 4'h7);
		close_out;
	end
endmodule : testbench
